// >>> src/omic_cfg.svh
// Constants for the operating mode and interrupt controller.
// Assumes a 200 MHz block clock; shared by the package and the mode controller.
//
// How it works
// - Power-up holds reset low 1 ms, then request
// - Regulator low, watchdog fail, sleep wake, timeout reset
// - Normal request times out after 150 ms
// - Stop wake enters normal request, regulator on
// - Grounded watchdog pin skips normal request
// - Normal mode enables functions; window needs resistor
// - Sleep on command or long regulator low
// - Regulator low without supply undervoltage gives sleep
// - Sleep: regulator off, few wake sources, cyclic sense
// - Sleep wake reports source, battery fail clear
// - Stop only by command, regulator limited
// - Stop wake raises interrupt except select, reset
// - Stop and sleep wake source sets differ
// - Missing or early trigger is watchdog failure
// - Pending wake sources block new fault interrupts
// - Interrupt low until source register read
// - No interrupt in sleep or while reset low
// - Fault interrupts maskable through the mask register
// - Supply under and overvoltage raise interrupts
// - Regulator, high-side, low-side overtemperature raise interrupts
// - LIN faults disable driver until recessive transmit
// - Reset output low 1 ms after source ends, except reset pin source: not driven, left when pin rises
// - Watchdog clear in first half fails
`ifndef OMIC_CFG_SVH
`define OMIC_CFG_SVH
`define OMIC_CLK_MHZ 200
`define OMIC_RST_HOLD_US 1000
`define OMIC_NREQ_TO_US 150000
`define OMIC_VDD_LOW_US 150000
`define OMIC_WD_PERIOD_US 150000
`define OMIC_LIN_WAKE_US 30
`define OMIC_MOD_NORMAL 2'h0
`define OMIC_MOD_STOP 2'h1
`define OMIC_MOD_SLEEP 2'h2
`define OMIC_INT_MASK_RST 6'h3f
`define OMIC_ST_RESET 3'h0
`define OMIC_ST_NREQ 3'h1
`define OMIC_ST_NORMAL 3'h3
`define OMIC_ST_STOP 3'h2
`define OMIC_ST_SLEEP 3'h6
`endif

// >>> src/omic_pkg.sv
// Types shared by the operating mode and interrupt controller.
// Assumes the constants header is on the include path.
`include "omic_cfg.svh"
package omic_pkg;
  typedef enum logic [2:0] {
    omic_st_reset  = `OMIC_ST_RESET,
    omic_st_nreq   = `OMIC_ST_NREQ,
    omic_st_normal = `OMIC_ST_NORMAL,
    omic_st_stop   = `OMIC_ST_STOP,
    omic_st_sleep  = `OMIC_ST_SLEEP
  } omic_mode_t;
  // Pin and monitor levels, all asynchronous to the block clock.
  typedef struct packed {
    logic cs_n;
    logic rst_n;
    logic wake_input_one;
    logic wake_input_two;
    logic lin_rx;
    logic txd;
    logic vdd_low;
    logic sup_uv;
    logic sup_ov;
    logic reg_ot;
    logic hs_ot;
    logic ls_ot;
    logic lin_ot;
    logic rxd_short;
    logic txd_stuck;
    logic wdcfg_gnd;
    logic wdcfg_res;
  } omic_pins_t;
  typedef struct packed {
    logic       mode_wr;
    logic [1:0] mode_sel;
    logic       timing_wr;
    logic       int_src_rd;
    logic       int_mask_wr;
    logic [5:0] int_mask_data;
  } omic_cmd_t;
  typedef struct packed {
    logic [1:0] wake_en;
    logic       cyclic_en;
    logic       forced_en;
    logic       lin_rx_only;
    logic       period_tick;
  } omic_wcfg_t;
  typedef struct packed {
    logic lx_wake;
    logic lin_wake;
    logic per_wake;
    logic sup_uv;
    logic sup_ov;
    logic reg_ot;
    logic hs_ot;
    logic ls_ot;
    logic lin_flt;
  } omic_int_src_t;
endpackage : omic_pkg

// >>> src/omic_timer.sv
// Cycle counter reporting half and full expiry of a span.
// Assumes run and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module omic_timer #(
  parameter int unsigned CYC = 16
) (
  input  wire logic ref_clk_in, // Block clock
  input  wire logic rst_n_in,   // Synchronous reset, active low
  input  wire logic run_in,     // Count while high, clear while low
  input  wire logic clr_in,     // Restart from zero
  output logic      half_out,   // Half the span elapsed
  output logic      done_out    // Full span elapsed, held until cleared
);
  localparam logic [31:0] LAST = 32'(CYC);
  localparam logic [31:0] HALF = 32'(CYC / 2);
  logic [31:0] cnt_reg;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || !run_in || clr_in) begin
      cnt_reg <= 32'h0;
    end else if (cnt_reg != LAST) begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end
  assign half_out = cnt_reg >= HALF;
  assign done_out = cnt_reg == LAST;
endmodule : omic_timer
`default_nettype wire

// >>> src/omic_mode_ctrl.sv
// Operating mode state machine with reset pin and interrupt pin control.
// Assumes decoded serial commands on the block clock; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "omic_cfg.svh"
module omic_mode_ctrl #(
  parameter int unsigned RST_HOLD_CYC = `OMIC_RST_HOLD_US * `OMIC_CLK_MHZ,
  parameter int unsigned NREQ_TO_CYC  = `OMIC_NREQ_TO_US * `OMIC_CLK_MHZ,
  parameter int unsigned VDD_LOW_CYC  = `OMIC_VDD_LOW_US * `OMIC_CLK_MHZ,
  parameter int unsigned WD_CYC       = `OMIC_WD_PERIOD_US * `OMIC_CLK_MHZ,
  parameter int unsigned LIN_WAKE_CYC = `OMIC_LIN_WAKE_US * `OMIC_CLK_MHZ
) (
  input  wire logic              ref_clk_in,            // Block clock
  input  wire logic              rst_n_in,              // Power-on reset, active low
  input  wire omic_pkg::omic_pins_t pins_in,            // Asynchronous pin levels
  input  wire omic_pkg::omic_cmd_t  cmd_in,             // Decoded serial commands
  input  wire omic_pkg::omic_wcfg_t wcfg_in,            // Wake-up set-up
  output omic_pkg::omic_mode_t   mode_out,              // Operating mode
  output logic                   rst_pin_out,           // Reset pin level when driven
  output logic                   rst_pin_oe_out,        // Reset pin pull-down on
  output logic                   irq_n_out,             // Interrupt pin, active low
  output logic                   reg_on_out,            // Regulator on
  output logic                   reg_limited_out,       // Regulator current limited
  output logic                   lin_tx_en_out,         // LIN transmitter enabled
  output logic                   lin_rx_en_out,         // LIN receiver enabled
  output logic                   func_en_out,           // Serial and PWM control live
  output logic                   hs_sense_out,          // High-side on for cyclic sense
  output logic                   battery_fail_flag_out, // Set by power-up
  output logic                   wd_off_out,            // Watchdog disabled by pin
  output omic_pkg::omic_int_src_t int_src_out           // Interrupt source register
);
  import omic_pkg::*;

  omic_pins_t    s1_reg;
  omic_pins_t    pin_reg;
  omic_pins_t    prev_reg;
  omic_mode_t    state_reg;
  omic_mode_t    state_next;
  logic          ext_hold_reg;
  logic          ext_hold_next;
  logic [2:0]    oe_hist_reg;
  logic          wd_win_reg;
  logic          timing_seen_reg;
  logic          lin_ok_reg;
  logic          lin_ok_next;
  logic [1:0]    lx_ref_reg;
  logic [5:0]    flt_prev_reg;
  logic [5:0]    int_mask_reg;
  logic [8:0]    int_src_next;
  logic          irq_n_next;

  // The first stage only feeds the second; edges are taken after the second.
  always_ff @(posedge ref_clk_in) begin
    s1_reg   <= pins_in;
    pin_reg  <= s1_reg;
    prev_reg <= pin_reg;
  end

  wire logic in_reset  = state_reg == omic_st_reset;
  wire logic in_nreq   = state_reg == omic_st_nreq;
  wire logic in_normal = state_reg == omic_st_normal;
  wire logic in_stop   = state_reg == omic_st_stop;
  wire logic in_sleep  = state_reg == omic_st_sleep;
  wire logic low_pwr   = in_stop | in_sleep;

  wire logic cmd_normal = cmd_in.mode_wr & (cmd_in.mode_sel == `OMIC_MOD_NORMAL);
  wire logic cmd_stop   = cmd_in.mode_wr & (cmd_in.mode_sel == `OMIC_MOD_STOP);
  wire logic cmd_sleep  = cmd_in.mode_wr & (cmd_in.mode_sel == `OMIC_MOD_SLEEP);

  // The pin reads back our own pull-down for three cycles after release.
  wire logic ext_low   = ~pin_reg.rst_n & ~rst_pin_oe_out & ~|oe_hist_reg;
  wire logic leave_tgt = pin_reg.wdcfg_gnd;

  wire logic hold_done;
  wire logic nreq_done;
  wire logic uvt_done;
  wire logic wd_half;
  wire logic wd_done;
  wire logic lin_done;
  wire logic wd_clear = in_normal & cmd_normal;
  wire logic wd_fail  = in_normal & ~wd_off_out &
                        (wd_done | (wd_clear & ~wd_half & wd_win_reg));

  omic_timer #(.CYC(RST_HOLD_CYC)) u_hold (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .run_in     (in_reset & ~pin_reg.vdd_low & ~ext_hold_reg),
    .clr_in     (1'b0),
    .half_out   (),
    .done_out   (hold_done)
  );
  omic_timer #(.CYC(NREQ_TO_CYC)) u_nreq (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .run_in     (in_nreq),
    .clr_in     (1'b0),
    .half_out   (),
    .done_out   (nreq_done)
  );
  omic_timer #(.CYC(VDD_LOW_CYC)) u_uvt (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .run_in     (in_reset & pin_reg.vdd_low & ~pin_reg.sup_uv),
    .clr_in     (1'b0),
    .half_out   (),
    .done_out   (uvt_done)
  );
  omic_timer #(.CYC(WD_CYC)) u_wd (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .run_in     (in_normal & ~wd_off_out),
    .clr_in     (wd_clear),
    .half_out   (wd_half),
    .done_out   (wd_done)
  );
  omic_timer #(.CYC(LIN_WAKE_CYC)) u_lin (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .run_in     (low_pwr & ~pin_reg.lin_rx),
    .clr_in     (1'b0),
    .half_out   (),
    .done_out   (lin_done)
  );

  // Wake sources; select and reset pin wakes count only in stop.
  wire logic [1:0] lx_now  = {pin_reg.wake_input_two, pin_reg.wake_input_one};
  wire logic lx_cmp   = wcfg_in.cyclic_en ? hs_sense_out : 1'b1;
  wire logic lx_wake  = low_pwr & lx_cmp & |((lx_now ^ lx_ref_reg) & wcfg_in.wake_en);
  wire logic lin_wake = low_pwr & lin_done & pin_reg.lin_rx & ~(in_stop & wcfg_in.lin_rx_only);
  wire logic per_wake = low_pwr & wcfg_in.forced_en & ~wcfg_in.cyclic_en & wcfg_in.period_tick;
  wire logic cs_wake  = in_stop & pin_reg.cs_n & ~prev_reg.cs_n;
  wire logic src_wake = lx_wake | lin_wake | per_wake;

  always_comb begin
    state_next    = state_reg;
    ext_hold_next = ext_hold_reg;
    case (state_reg)
      omic_st_reset: begin
        if (uvt_done) begin
          state_next = omic_st_sleep;
        end else if (ext_hold_reg ? pin_reg.rst_n : hold_done) begin
          state_next    = leave_tgt ? omic_st_normal : omic_st_nreq;
          ext_hold_next = 1'b0;
        end
      end
      omic_st_nreq: begin
        if (pin_reg.vdd_low || nreq_done) begin
          state_next = omic_st_reset;
        end else if (ext_low) begin
          state_next    = omic_st_reset;
          ext_hold_next = 1'b1;
        end else if (cmd_normal && timing_seen_reg) begin
          state_next = omic_st_normal;
        end
      end
      omic_st_normal: begin
        if (pin_reg.vdd_low || wd_fail) begin
          state_next = omic_st_reset;
        end else if (ext_low) begin
          state_next    = omic_st_reset;
          ext_hold_next = 1'b1;
        end else if (cmd_sleep) begin
          state_next = omic_st_sleep;
        end else if (cmd_stop) begin
          state_next = omic_st_stop;
        end
      end
      omic_st_stop: begin
        if (pin_reg.vdd_low) begin
          state_next = omic_st_reset;
        end else if (ext_low) begin
          state_next    = omic_st_reset;
          ext_hold_next = 1'b1;
        end else if (src_wake || cs_wake) begin
          state_next = omic_st_nreq;
        end
      end
      omic_st_sleep: begin
        if (src_wake) begin
          state_next = omic_st_reset;
        end
      end
      default: begin
        state_next = omic_st_reset;
      end
    endcase
  end

  // Interrupt sources: wakes are never masked, faults are edge events.
  wire logic       lin_flt  = pin_reg.lin_ot | pin_reg.txd_stuck | pin_reg.rxd_short;
  wire logic [5:0] flt_now  = {pin_reg.sup_uv, pin_reg.sup_ov, pin_reg.reg_ot,
                               pin_reg.hs_ot, pin_reg.ls_ot, lin_flt};
  wire logic [5:0] flt_set  = (in_nreq | in_normal) ?
                              (flt_now & ~flt_prev_reg & int_mask_reg) : 6'h00;
  wire logic [2:0] wake_set = {lx_wake, lin_wake, per_wake};
  wire logic       wake_pend = int_src_out.lx_wake | int_src_out.lin_wake | int_src_out.per_wake;
  wire logic       irq_mode = in_nreq | in_normal | in_stop;
  wire logic       irq_ok   = irq_mode & pin_reg.rst_n & ~rst_pin_oe_out & ~|oe_hist_reg;
  wire logic       raise    = irq_ok & (in_stop ? |wake_set : (|flt_set & ~wake_pend));
  wire logic       next_irq_mode = (state_next == omic_st_nreq) | (state_next == omic_st_normal) |
                                   (state_next == omic_st_stop);

  // A source that fires in the read cycle survives the clear.
  assign int_src_next = {wake_set, flt_set} | (int_src_out & ~{9{cmd_in.int_src_rd}});
  assign irq_n_next   = raise ? 1'b0 :
                        ((cmd_in.int_src_rd | ~next_irq_mode) ? 1'b1 : irq_n_out);
  assign lin_ok_next  = lin_flt ? 1'b0 : (pin_reg.txd ? 1'b1 : lin_ok_reg);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_reg    <= omic_st_reset;
      ext_hold_reg <= 1'b0;
      rst_pin_oe_out <= 1'b1;
      oe_hist_reg  <= 3'h7;
      lx_ref_reg   <= 2'h0;
    end else begin
      state_reg    <= state_next;
      ext_hold_reg <= ext_hold_next;
      rst_pin_oe_out <= (state_next == omic_st_reset) & ~ext_hold_next;
      oe_hist_reg  <= {oe_hist_reg[1:0], rst_pin_oe_out};
      if (!low_pwr || (wcfg_in.cyclic_en && hs_sense_out)) begin
        lx_ref_reg <= lx_now;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      mode_out        <= omic_st_reset;
      reg_on_out      <= 1'b1;
      reg_limited_out <= 1'b0;
      func_en_out     <= 1'b0;
      lin_rx_en_out   <= 1'b0;
      lin_tx_en_out   <= 1'b0;
      lin_ok_reg      <= 1'b0;
    end else begin
      mode_out        <= state_next;
      reg_on_out      <= state_next != omic_st_sleep;
      reg_limited_out <= state_next == omic_st_stop;
      func_en_out     <= (state_next == omic_st_nreq) | (state_next == omic_st_normal);
      lin_rx_en_out   <= next_irq_mode;
      lin_tx_en_out   <= (state_next == omic_st_normal) & lin_ok_next;
      lin_ok_reg      <= lin_ok_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      irq_n_out             <= 1'b1;
      int_src_out           <= '0;
      int_mask_reg          <= `OMIC_INT_MASK_RST;
      flt_prev_reg          <= 6'h00;
      battery_fail_flag_out <= 1'b1;
      wd_off_out            <= 1'b0;
      wd_win_reg            <= 1'b0;
      timing_seen_reg       <= 1'b0;
      hs_sense_out          <= 1'b0;
      rst_pin_out           <= 1'b0;
    end else begin
      irq_n_out    <= irq_n_next;
      int_src_out  <= omic_int_src_t'(int_src_next);
      flt_prev_reg <= flt_now;
      rst_pin_out  <= 1'b0;
      hs_sense_out <= low_pwr & wcfg_in.cyclic_en & wcfg_in.period_tick;
      if (cmd_in.int_mask_wr) begin
        int_mask_reg <= cmd_in.int_mask_data;
      end
      if (cmd_in.int_src_rd) begin
        battery_fail_flag_out <= 1'b0;
      end
      if (in_reset) begin
        wd_off_out <= pin_reg.wdcfg_gnd;
        wd_win_reg <= pin_reg.wdcfg_res;
      end
      timing_seen_reg <= in_nreq & (timing_seen_reg | cmd_in.timing_wr);
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_rst_low;
    (state_reg == omic_st_reset && !ext_hold_reg) |-> rst_pin_oe_out && !rst_pin_out;
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("Reset pin not pulled low in reset mode.");

  property p_nreq_timeout;
    (in_nreq && nreq_done) |=> state_reg == omic_st_reset;
  endproperty
  a_nreq_timeout: assert property (p_nreq_timeout) else $error("Normal request timeout ignored.");

  property p_wd_gnd;
    (in_reset && !ext_hold_reg && hold_done && !uvt_done && pin_reg.wdcfg_gnd)
      |=> state_reg == omic_st_normal ##1 wd_off_out;
  endproperty
  a_wd_gnd: assert property (p_wd_gnd) else $error("Grounded watchdog pin did not skip request.");

  property p_sleep_entry;
    (state_reg == omic_st_sleep && $past(state_reg) != omic_st_sleep)
      |-> $past(in_normal && cmd_sleep) || $past(in_reset && uvt_done);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("Sleep entered without cause.");

  property p_stop_entry;
    (state_reg == omic_st_stop && $past(state_reg) != omic_st_stop) |-> $past(cmd_stop);
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("Stop entered without command.");

  property p_early_clear;
    (in_normal && !wd_off_out && wd_win_reg && wd_clear && !wd_half)
      |=> state_reg == omic_st_reset && rst_pin_oe_out;
  endproperty
  a_early_clear: assert property (p_early_clear) else $error("Early watchdog clear accepted.");

  property p_irq_ack;
    (cmd_in.int_src_rd && !raise) |=> irq_n_out [*2] or (irq_n_out ##1 !irq_n_out);
  endproperty
  a_irq_ack: assert property (p_irq_ack) else $error("Interrupt pin not released after read.");

  property p_irq_sleep;
    in_sleep |-> irq_n_out;
  endproperty
  a_irq_sleep: assert property (p_irq_sleep) else $error("Interrupt asserted in sleep mode.");

  property p_stop_wake;
    (in_stop && lx_wake && !pin_reg.vdd_low && !ext_low)
      |=> state_reg == omic_st_nreq && !irq_n_out && int_src_out.lx_wake;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("Stop wake missed mode or interrupt.");

  property p_lin_off;
    lin_flt |=> !lin_tx_en_out;
  endproperty
  a_lin_off: assert property (p_lin_off) else $error("LIN driver enabled during fault.");
endmodule : omic_mode_ctrl
`default_nettype wire

// >>> test/omic_host_model.sv
// Host microcontroller model that issues decoded serial commands to the mode controller.
// Assumes the bench calls its tasks; every command is a one-cycle pulse launched at a falling edge.
`timescale 1ns/1ps
`default_nettype none
module omic_host_model (
  input  wire logic          ref_clk_in, // Block clock
  output omic_pkg::omic_cmd_t cmd_out     // Decoded serial commands
);
  import omic_pkg::*;

  initial cmd_out = '0;

  task automatic pulse(input omic_cmd_t c);
    @(negedge ref_clk_in);
    cmd_out = c;
    @(negedge ref_clk_in);
    cmd_out = '0;
  endtask : pulse

  task automatic set_mode(input logic [1:0] sel);
    omic_cmd_t c;
    c = '0;
    c.mode_wr = 1'b1;
    c.mode_sel = sel;
    pulse(c);
  endtask : set_mode

  // Timing write first, then mode bits zero, is the only way from normal request into normal mode.
  task automatic go_normal();
    omic_cmd_t c;
    c = '0;
    c.timing_wr = 1'b1;
    pulse(c);
    set_mode(2'h0);
  endtask : go_normal

  // Reading the source register is the acknowledge.
  task automatic ack();
    omic_cmd_t c;
    c = '0;
    c.int_src_rd = 1'b1;
    pulse(c);
  endtask : ack

  task automatic mask(input logic [5:0] m);
    omic_cmd_t c;
    c = '0;
    c.int_mask_wr = 1'b1;
    c.int_mask_data = m;
    pulse(c);
  endtask : mask
endmodule : omic_host_model
`default_nettype wire

// >>> test/omic_mode_ctrl_test.sv
// Self-checking bench for the operating mode and interrupt controller.
// Assumes shortened counts; pins are driven at the falling edge by the bench.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module omic_mode_ctrl_test;
  import omic_pkg::*;
  logic          clk;
  logic          rst_n;
  omic_pins_t    pins;
  omic_cmd_t     cmd;
  omic_wcfg_t    wcfg;
  omic_mode_t    mode;
  logic          oe;
  logic          irq_n;
  logic          reg_on;
  logic          reg_lim;
  logic          lin_tx;
  logic          func_en;
  logic          bf;
  logic          wd_off;
  logic          rst_pin;
  logic          lin_rx_en;
  logic          hs_sense;
  omic_int_src_t src;
  int            miscompares;
  int            n_tests;
  int            i;

  always #2.5 clk = ~clk;

  omic_host_model host (.ref_clk_in(clk), .cmd_out(cmd));

  omic_mode_ctrl #(.RST_HOLD_CYC(20), .NREQ_TO_CYC(200), .VDD_LOW_CYC(100), .WD_CYC(100),
    .LIN_WAKE_CYC(10)) dut (
    .ref_clk_in(clk), .rst_n_in(rst_n), .pins_in(pins), .cmd_in(cmd), .wcfg_in(wcfg),
    .mode_out(mode), .rst_pin_out(rst_pin), .rst_pin_oe_out(oe), .irq_n_out(irq_n), .reg_on_out(reg_on),
    .reg_limited_out(reg_lim), .lin_tx_en_out(lin_tx), .lin_rx_en_out(lin_rx_en), .func_en_out(func_en),
    .hs_sense_out(hs_sense), .battery_fail_flag_out(bf), .wd_off_out(wd_off), .int_src_out(src));

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic wait_mode(input omic_mode_t m, input int n);
    for (int k = 0; k < n && mode !== m; k++) @(negedge clk);
    `CHK(mode, m)
    if (mode !== m) finish_test();
  endtask : wait_mode

  task automatic wait_irq(input int n);
    for (int k = 0; k < n && irq_n !== 1'b0; k++) @(negedge clk);
    `CHK(irq_n, 1'b0)
  endtask : wait_irq

  task automatic t_powerup();
    `CHK(mode, omic_st_reset)
    `CHK({oe, rst_pin}, 2'b10)
    `CHK(bf, 1'b1)
    wait_mode(omic_st_nreq, 40);
    `CHK(oe, 1'b0)
    `CHK({reg_on, lin_tx, lin_rx_en}, 3'b101)
    $display("Test powerup done");
  endtask : t_powerup

  task automatic t_timeout();
    for (i = 0; i < 300 && mode === omic_st_nreq; i++) @(negedge clk);
    `CHK(mode, omic_st_reset)
    `CHK(i > 180 && i < 230, 1'b1)
    wait_mode(omic_st_nreq, 40);
    $display("Test timeout done");
  endtask : t_timeout

  task automatic t_normal();
    host.set_mode(2'h0);
    repeat (3) @(negedge clk);
    `CHK(mode, omic_st_nreq)
    host.go_normal();
    wait_mode(omic_st_normal, 5);
    `CHK(func_en, 1'b1)
    $display("Test normal done");
  endtask : t_normal

  task automatic t_fault();
    pins.sup_uv = 1'b1;
    wait_irq(10);
    `CHK(src.sup_uv, 1'b1)
    repeat (3) @(negedge clk);
    `CHK(irq_n, 1'b0)
    host.ack();
    @(negedge clk);
    `CHK({irq_n, src}, {1'b1, 9'h000})
    host.mask(6'h00);
    pins.sup_ov = 1'b1;
    repeat (10) @(negedge clk);
    `CHK({irq_n, src.sup_ov}, 2'b10)
    host.mask(6'h3f);
    pins.reg_ot = 1'b1;
    wait_irq(10);
    `CHK(src.reg_ot, 1'b1)
    host.ack();
    host.set_mode(2'h0);
    $display("Test fault done");
  endtask : t_fault

  // The driver stays off after a fault until the transmit input is recessive again.
  task automatic t_lin();
    `CHK(lin_tx, 1'b1)
    pins.txd_stuck = 1'b1;
    pins.txd = 1'b0;
    wait_irq(10);
    `CHK({lin_tx, src.lin_flt}, 2'b01)
    host.ack();
    pins.txd_stuck = 1'b0;
    repeat (5) @(negedge clk);
    `CHK(lin_tx, 1'b0)
    pins.txd = 1'b1;
    pins.hs_ot = 1'b1;
    pins.ls_ot = 1'b1;
    wait_irq(10);
    `CHK({lin_tx, src.hs_ot, src.ls_ot}, 3'b111)
    host.ack();
    pins.lin_ot = 1'b1;
    wait_irq(10);
    `CHK({lin_tx, src.lin_flt}, 2'b01)
    host.ack();
    pins.lin_ot = 1'b0;
    host.set_mode(2'h0);
    $display("Test lin done");
  endtask : t_lin

  task automatic t_wdog();
    pins.wdcfg_res = 1'b1;
    for (i = 0; i < 150 && mode === omic_st_normal; i++) @(negedge clk);
    `CHK(mode, omic_st_reset)
    `CHK(i > 80 && i < 110, 1'b1)
    wait_mode(omic_st_nreq, 40);
    host.go_normal();
    wait_mode(omic_st_normal, 5);
    host.set_mode(2'h0);
    wait_mode(omic_st_reset, 5);
    `CHK(oe, 1'b1)
    wait_mode(omic_st_nreq, 40);
    host.go_normal();
    wait_mode(omic_st_normal, 5);
    repeat (60) @(negedge clk);
    host.set_mode(2'h0);
    repeat (3) @(negedge clk);
    `CHK(mode, omic_st_normal)
    $display("Test watchdog done");
  endtask : t_wdog

  task automatic t_stop();
    host.set_mode(2'h1);
    wait_mode(omic_st_stop, 5);
    `CHK(reg_lim, 1'b1)
    pins.wake_input_one = 1'b1;
    wait_mode(omic_st_nreq, 10);
    wait_irq(3);
    `CHK(src.lx_wake, 1'b1)
    host.ack();
    host.go_normal();
    wait_mode(omic_st_normal, 5);
    host.set_mode(2'h1);
    wait_mode(omic_st_stop, 5);
    pins.cs_n = 1'b0;
    repeat (4) @(negedge clk);
    pins.cs_n = 1'b1;
    wait_mode(omic_st_nreq, 10);
    repeat (3) @(negedge clk);
    `CHK(irq_n, 1'b1)
    host.go_normal();
    wait_mode(omic_st_normal, 5);
    $display("Test stop done");
  endtask : t_stop

  task automatic t_sleep();
    host.set_mode(2'h2);
    wait_mode(omic_st_sleep, 5);
    `CHK(reg_on, 1'b0)
    pins.cs_n = 1'b0;
    repeat (4) @(negedge clk);
    pins.cs_n = 1'b1;
    repeat (6) @(negedge clk);
    `CHK(mode, omic_st_sleep)
    pins.wdcfg_gnd = 1'b1;
    pins.wake_input_one = 1'b0;
    wait_mode(omic_st_reset, 10);
    `CHK({oe, irq_n, bf, src.lx_wake}, 4'b1101)
    wait_mode(omic_st_normal, 40);
    `CHK(wd_off, 1'b1)
    $display("Test sleep done");
  endtask : t_sleep

  // The sleep wake bit is still pending here, so a new fault must stay silent.
  task automatic t_vdd();
    pins.lin_ot = 1'b1;
    repeat (5) @(negedge clk);
    `CHK(irq_n, 1'b1)
    host.ack();
    pins.lin_ot = 1'b0;
    pins.sup_uv = 1'b0;
    pins.vdd_low = 1'b1;
    wait_mode(omic_st_reset, 5);
    `CHK(oe, 1'b1)
    wait_mode(omic_st_sleep, 120);
    `CHK({reg_on, lin_rx_en}, 2'b00)
    pins.vdd_low = 1'b0;
    wcfg.forced_en = 1'b1;
    wcfg.period_tick = 1'b1;
    @(negedge clk);
    wcfg.period_tick = 1'b0;
    `CHK({mode, irq_n, src.per_wake}, {omic_st_reset, 2'b11})
    wait_mode(omic_st_normal, 40);
    $display("Test vdd done");
  endtask : t_vdd

  task automatic t_wake();
    wcfg.forced_en = 1'b0;
    wcfg.cyclic_en = 1'b1;
    host.set_mode(2'h1);
    wait_mode(omic_st_stop, 5);
    pins.wake_input_one = 1'b1;
    repeat (6) @(negedge clk);
    `CHK({mode, hs_sense}, {omic_st_stop, 1'b0})
    wcfg.period_tick = 1'b1;
    @(negedge clk);
    wcfg.period_tick = 1'b0;
    `CHK(hs_sense, 1'b1)
    wait_mode(omic_st_nreq, 3);
    wait_irq(3);
    `CHK(src.lx_wake, 1'b1)
    host.ack();
    host.go_normal();
    wait_mode(omic_st_normal, 5);
    wcfg.cyclic_en = 1'b0;
    host.set_mode(2'h1);
    wait_mode(omic_st_stop, 5);
    pins.lin_rx = 1'b0;
    repeat (15) @(negedge clk);
    pins.lin_rx = 1'b1;
    wait_mode(omic_st_nreq, 10);
    wait_irq(3);
    `CHK(src.lin_wake, 1'b1)
    host.ack();
    $display("Test wake done");
  endtask : t_wake

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    miscompares = 0;
    n_tests = 0;
    pins = '0;
    pins.cs_n = 1'b1;
    pins.rst_n = 1'b1;
    pins.lin_rx = 1'b1;
    pins.txd = 1'b1;
    wcfg = '0;
    wcfg.wake_en = 2'b01;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_powerup();
    t_timeout();
    t_normal();
    t_fault();
    t_lin();
    t_wdog();
    t_stop();
    t_sleep();
    t_vdd();
    t_wake();
    finish_test();
  end

  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
endmodule : omic_mode_ctrl_test
`default_nettype wire
